// ---- bench/ceim_host_model.sv ----
// Host model at the far side: owns the register port and watches the request line.
// Assumes the bench calls wr and rd by hierarchy, one at a time, after reset release.
`timescale 1ns/1ps
module ceim_host_model
    import ceim_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [ADDR_W-1:0] regAddr,
    output logic regWrEn,
    output logic [DATA_W-1:0] regWrData,
    output logic regRdEn,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic regRdValid,
    // Interrupt request
    input wire logic irq
);
    initial begin
        regAddr = '0;
        regWrEn = 1'b0;
        regWrData = '0;
        regRdEn = 1'b0;
    end

    // Released lines show the inverse so stale values never pass for live ones
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        // Answer is registered, so it stands at the edge after the one that took the read
        @(posedge clk);
        // Missing valid strobe turns the answer unknown, so it fails the compare
        d = (regRdValid === 1'b1) ? regRdData : 'x;
    endtask

    // Request line is a registered level, taken at an edge like the read data
    task automatic sampleIrq(output logic v);
        @(posedge clk);
        v = irq;
    endtask
endmodule

// ---- bench/clock_event_irq_masking_bench.sv ----
// Self-checking bench for the clock event interrupt block.
// Assumes the host model for register traffic; conditions driven here.
`timescale 1ns/1ps
module clock_event_irq_masking_bench
    import ceim_pkg::*;
;
    logic clk;
    logic srst;
    logic [ADDR_W-1:0] regAddr;
    logic regWrEn;
    logic [DATA_W-1:0] regWrData;
    logic regRdEn;
    logic [DATA_W-1:0] regRdData;
    logic regRdValid;
    logic [1:0] loopLostLock;
    logic [1:0] loopHoldover;
    logic [NUM_REFS*NUM_MONS-1:0] refMonitorFault;
    logic [NUM_REFS*NUM_MONS-1:0] refMonitorEnable;
    logic irq;
    int numErrors;
    int checksDone;
    logic [31:0] seed;

    ceim_top DUT (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .loopLostLock(loopLostLock), .loopHoldover(loopHoldover),
        .refMonitorFault(refMonitorFault), .refMonitorEnable(refMonitorEnable), .irq(irq));

    ceim_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reference k fails when any enabled monitor reports and its event enable is set
    function automatic logic [NUM_REFS-1:0] refExpect(input logic [54:0] f,
            input logic [54:0] m, input logic [NUM_REFS-1:0] en);
        logic [NUM_REFS-1:0] r;
        for (int k = 0; k < NUM_REFS; k++) begin
            r[k] = (|(f[k*5+:5] & m[k*5+:5])) & en[k];
        end
        return r;
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic readCheck(input string what, input logic [ADDR_W-1:0] a,
            input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check(what, exp, d);
    endtask

    task automatic reportAndStop();
        $display("Counts: checks %0d, mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        reportAndStop();
    end

    initial begin
        logic [NUM_REFS-1:0] refEn;
        logic [NUM_REFS-1:0] exp;
        logic [54:0] f;
        logic [54:0] m;
        logic [1:0] ll;
        logic [1:0] ho;
        logic irqSeen;
        seed = 32'h92289D56;
        numErrors = 0;
        checksDone = 0;
        srst = 1'b1;
        loopLostLock = 2'b00;
        loopHoldover = 2'b00;
        refMonitorFault = '0;
        refMonitorEnable = '0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        // Reset values, reserved enable bits, unmapped place
        for (int a = 12'h020; a <= 12'h025; a++) begin
            readCheck("reset value", a[ADDR_W-1:0], 8'h00);
        end
        check("irq after reset", 8'h00, {7'h00, irq});
        host.wr(12'h024, 8'hFF);
        readCheck("ref high enable", 12'h024, 8'h07);
        host.wr(12'h025, 8'hFF);
        readCheck("loop enable", 12'h025, 8'h0F);
        host.wr(12'h0FF, 8'hFF);
        readCheck("unmapped", 12'h0FF, 8'h00);
        $display("test registers done");
        // Each loop event alone enabled; all conditions pulse for one cycle
        for (int i = 0; i < LOOP_BITS; i++) begin
            host.wr(LOOP_ENABLE_ADDR, 8'h01 << i);
            @(posedge clk);
            loopLostLock <= 2'b11;
            loopHoldover <= 2'b11;
            @(posedge clk);
            loopLostLock <= 2'b00;
            loopHoldover <= 2'b00;
            repeat (3) @(posedge clk);
            readCheck("loop status", LOOP_STATUS_ADDR, 8'h01 << i);
            check("irq on loop event", 8'h01, {7'h00, irq});
            host.wr(LOOP_STATUS_ADDR, 8'hFF);
            @(posedge clk);
            host.sampleIrq(irqSeen);
            check("irq after clear", 8'h00, {7'h00, irqSeen});
            readCheck("loop status cleared", LOOP_STATUS_ADDR, 8'h00);
        end
        $display("test loop events done");
        // Live levels with every loop event masked
        host.wr(LOOP_ENABLE_ADDR, 8'h00);
        for (int r = 0; r < 4; r++) begin
            ll = 2'(rnd());
            ho = 2'(rnd());
            @(posedge clk);
            loopLostLock <= ll;
            loopHoldover <= ho;
            repeat (2) @(posedge clk);
            readCheck("live hold lock", HOLD_LOCK_ADDR, {4'h0, ll[1], ho[1], ll[0], ho[0]});
            readCheck("masked loop status", LOOP_STATUS_ADDR, 8'h00);
        end
        @(posedge clk);
        loopLostLock <= 2'b00;
        loopHoldover <= 2'b00;
        $display("test live levels done");
        // Reference failures: all-ones corner first, then random
        for (int r = 0; r < 6; r++) begin
            refEn = (r == 0) ? '1 : NUM_REFS'(rnd());
            f = (r == 0) ? '1 : 55'({rnd(), rnd()});
            m = (r == 0) ? '1 : 55'({rnd(), rnd()});
            exp = refExpect(f, m, refEn);
            host.wr(REF_LO_ENABLE_ADDR, refEn[7:0]);
            host.wr(REF_HI_ENABLE_ADDR, {5'h00, refEn[10:8]});
            @(posedge clk);
            refMonitorFault <= f;
            refMonitorEnable <= m;
            @(posedge clk);
            refMonitorFault <= '0;
            repeat (3) @(posedge clk);
            readCheck("ref status low", REF_LO_STATUS_ADDR, exp[7:0]);
            readCheck("ref status high", REF_HI_STATUS_ADDR, {5'h00, exp[10:8]});
            check("irq on ref event", {7'h00, |exp}, {7'h00, irq});
            for (int k = 0; k < NUM_REFS; k++) begin
                readCheck("monitor faults", ADDR_W'(MON_FIRST_ADDR + k), {3'h0, f[k*5+:5]});
                host.wr(ADDR_W'(MON_FIRST_ADDR + k), 8'hFF);
            end
            host.wr(REF_LO_STATUS_ADDR, 8'hFF);
            host.wr(REF_HI_STATUS_ADDR, 8'hFF);
            @(posedge clk);
            host.sampleIrq(irqSeen);
            check("irq after ref clear", 8'h00, {7'h00, irqSeen});
            readCheck("ref status cleared", REF_LO_STATUS_ADDR, 8'h00);
            readCheck("monitor cleared", ADDR_W'(MON_FIRST_ADDR + (r % NUM_REFS)), 8'h00);
        end
        $display("test reference events done");
        reportAndStop();
    end
endmodule

// ---- verilog/ceim_flag_if.sv ----
// Carrier between the top and a sticky flag bank: set and clear requests, held flags.
// Assumes one clock domain; the user side drives requests every cycle.
`timescale 1ns/1ps
interface ceim_flag_if #(parameter int W = 4);
    logic [W-1:0] setReq;
    logic [W-1:0] clrReq;
    logic [W-1:0] flags;

    modport owner (input setReq, input clrReq, output flags);
    modport user (output setReq, output clrReq, input flags);
endinterface

// ---- verilog/ceim_irq_gen.sv ----
// Interrupt request output: high while any enabled sticky flag is held.
// Assumes flags and enables arrive as registered levels.
`timescale 1ns/1ps
module ceim_irq_gen
    import ceim_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Loop flags and enables
    input wire logic [LOOP_BITS-1:0] loopFlags,
    input wire logic [LOOP_BITS-1:0] loopEnable,
    // Reference flags and enables
    input wire logic [NUM_REFS-1:0] refFlags,
    input wire logic [NUM_REFS-1:0] refEnable,
    // Request line
    output logic irq
);
    typedef struct packed {
        logic irq;
    } ceim_irq_t;

    ceim_irq_t st_q;
    ceim_irq_t st_d;

    always_comb begin
        st_d = st_q;
        // Level, not pulse: stays up until every enabled flag is cleared
        st_d.irq = (|(loopFlags & loopEnable)) | (|(refFlags & refEnable));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign irq = st_q.irq;
endmodule

// ---- verilog/ceim_pkg.sv ----
// Constants for the clock event interrupt block: register map, field layout, reset values.
// Assumes an 8-bit register port with a 12-bit byte address.
package ceim_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_REFS = 11;
    localparam int NUM_MONS = 5;
    localparam int LOOP_BITS = 4;
    localparam int REF_LO_W = 8;
    localparam int REF_HI_W = 3;

    localparam logic [ADDR_W-1:0] REF_LO_STATUS_ADDR = 12'h020;
    localparam logic [ADDR_W-1:0] REF_HI_STATUS_ADDR = 12'h021;
    localparam logic [ADDR_W-1:0] LOOP_STATUS_ADDR = 12'h022;
    localparam logic [ADDR_W-1:0] REF_LO_ENABLE_ADDR = 12'h023;
    localparam logic [ADDR_W-1:0] REF_HI_ENABLE_ADDR = 12'h024;
    localparam logic [ADDR_W-1:0] LOOP_ENABLE_ADDR = 12'h025;
    localparam logic [ADDR_W-1:0] MON_FIRST_ADDR = 12'h026;
    localparam logic [ADDR_W-1:0] MON_LAST_ADDR = 12'h030;
    localparam logic [ADDR_W-1:0] HOLD_LOCK_ADDR = 12'h031;

    localparam int LOOP1_LOST_BIT = 3;
    localparam int LOOP1_HOLD_BIT = 2;
    localparam int LOOP0_LOST_BIT = 1;
    localparam int LOOP0_HOLD_BIT = 0;

    localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

endpackage

// ---- verilog/ceim_sticky.sv ----
// Bank of sticky flags: set by hardware, cleared by request, set beats clear.
// Assumes synchronous active-high reset on the single system clock.
`timescale 1ns/1ps
module ceim_sticky
    import ceim_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Flag carrier
    ceim_flag_if.owner fl
);
    typedef struct packed {
        logic [W-1:0] flags;
    } ceim_sticky_t;

    ceim_sticky_t st_q;
    ceim_sticky_t st_d;

    always_comb begin
        st_d = st_q;
        // Event landing with its clear must not be lost
        st_d.flags = (st_q.flags & ~fl.clrReq) | fl.setReq;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign fl.flags = st_q.flags;

    setWins_a: assert property (@(posedge clk) disable iff (srst)
        (|fl.setReq) |=> ((fl.flags & $past(fl.setReq)) == $past(fl.setReq)))
        else $error("sticky flag lost its set");
endmodule

// ---- verilog/ceim_top.sv ----
// Clock event interrupt status and masking with its 8-bit register port.
// Assumes monitor and loop conditions are levels synchronous to clk.
`timescale 1ns/1ps
// Summary of operation
// - Loop one lost lock sets status bit 3 when its enable bit is high.
// - Loop one holdover sets status bit 2 when its enable bit is high.
// - Any loop status bit set with its enable bit high drives the interrupt request high.
// - Loop status bits stay set until software clears them.
// - Loop zero uses bit 1 for lost lock, bit 0 for holdover, same behaviour.
// - Live lost-lock and holdover levels readable in a separate status register.
// - Low reference enable bit 7 passes or blocks reference seven failure.
// - Low reference enable bits 6..0 gate references six to zero likewise.
// - High reference enable bits 2..0 gate references ten to eight; 7:3 reserved.
// - Loop enable bit 3 gates loop one lost lock.
// - Loop enable bit 2 gates loop one holdover.
// - Loop enable bits 1 and 0 gate loop zero lost lock and holdover.
// - Reference failure sets when enabled and any enabled monitor reports failure.
// - Reference failure status at 0x020 bits 7..0, 0x021 bits 2..0, sticky.
// - Per-reference monitor fault bits latch regardless of masks, until cleared.
module ceim_top
    import ceim_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    output logic regRdValid,
    // Loop conditions
    input wire logic [1:0] loopLostLock,
    input wire logic [1:0] loopHoldover,
    // Reference monitors, five bits per reference
    input wire logic [NUM_REFS*NUM_MONS-1:0] refMonitorFault,
    input wire logic [NUM_REFS*NUM_MONS-1:0] refMonitorEnable,
    // Interrupt request
    output logic irq
);
    typedef struct packed {
        logic [REF_LO_W-1:0] refLoEnable;
        logic [REF_HI_W-1:0] refHiEnable;
        logic [LOOP_BITS-1:0] loopEnable;
        logic [LOOP_BITS-1:0] holdLock;
        logic [DATA_W-1:0] rdData;
        logic rdValid;
    } ceim_top_t;

    ceim_top_t st_q;
    ceim_top_t st_d;

    ceim_flag_if #(.W(LOOP_BITS)) loopIf ();
    ceim_flag_if #(.W(NUM_REFS)) refIf ();
    ceim_flag_if #(.W(NUM_REFS*NUM_MONS)) monIf ();

    function automatic logic isMonAddr(input logic [ADDR_W-1:0] a);
        return (a >= MON_FIRST_ADDR) && (a <= MON_LAST_ADDR);
    endfunction

    function automatic logic [3:0] monIndex(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] diff;
        diff = a - MON_FIRST_ADDR;
        return diff[3:0];
    endfunction

    logic [LOOP_BITS-1:0] loopLive;
    logic [NUM_REFS-1:0] refEnable;
    logic [NUM_REFS-1:0] refFailNow;
    logic [NUM_REFS*NUM_MONS-1:0] monClr;
    logic wrRefLo;
    logic wrRefHi;
    logic wrLoop;

    assign loopLive[LOOP1_LOST_BIT] = loopLostLock[1];
    assign loopLive[LOOP1_HOLD_BIT] = loopHoldover[1];
    assign loopLive[LOOP0_LOST_BIT] = loopLostLock[0];
    assign loopLive[LOOP0_HOLD_BIT] = loopHoldover[0];

    assign refEnable = {st_q.refHiEnable, st_q.refLoEnable};

    assign wrRefLo = regWrEn && (regAddr == REF_LO_STATUS_ADDR);
    assign wrRefHi = regWrEn && (regAddr == REF_HI_STATUS_ADDR);
    assign wrLoop = regWrEn && (regAddr == LOOP_STATUS_ADDR);

    // Loop events only reach the sticky bits through their enable bits
    assign loopIf.setReq = loopLive & st_q.loopEnable;
    assign loopIf.clrReq = wrLoop ? regWrData[LOOP_BITS-1:0] : '0;

    genvar k;
    generate
        for (k = 0; k < NUM_REFS; k++) begin : gRef
            // Live monitor levels, so a cleared fault can still trip the reference
            assign refFailNow[k] = |(refMonitorFault[k*NUM_MONS +: NUM_MONS] &
                                     refMonitorEnable[k*NUM_MONS +: NUM_MONS]);
            assign monClr[k*NUM_MONS +: NUM_MONS] =
                (regWrEn && isMonAddr(regAddr) && (monIndex(regAddr) == 4'(k))) ?
                regWrData[NUM_MONS-1:0] : '0;
        end
    endgenerate

    assign refIf.setReq = refFailNow & refEnable;
    assign refIf.clrReq = {(wrRefHi ? regWrData[REF_HI_W-1:0] : 3'h0),
                           (wrRefLo ? regWrData : 8'h00)};

    // Monitor faults are unmasked by design
    assign monIf.setReq = refMonitorFault;
    assign monIf.clrReq = monClr;

    ceim_sticky #(.W(LOOP_BITS)) uLoopFlags (
        .clk(clk),
        .srst(srst),
        .fl(loopIf.owner)
    );

    ceim_sticky #(.W(NUM_REFS)) uRefFlags (
        .clk(clk),
        .srst(srst),
        .fl(refIf.owner)
    );

    ceim_sticky #(.W(NUM_REFS*NUM_MONS)) uMonFlags (
        .clk(clk),
        .srst(srst),
        .fl(monIf.owner)
    );

    ceim_irq_gen uIrq (
        .clk(clk),
        .srst(srst),
        .loopFlags(loopIf.flags),
        .loopEnable(st_q.loopEnable),
        .refFlags(refIf.flags),
        .refEnable(refEnable),
        .irq(irq)
    );

    always_comb begin
        logic [3:0] idx;
        idx = monIndex(regAddr);
        st_d = st_q;
        st_d.holdLock = loopLive;
        st_d.rdValid = regRdEn;
        if (regWrEn) begin
            case (regAddr)
                REF_LO_ENABLE_ADDR: begin
                    st_d.refLoEnable = regWrData;
                end
                REF_HI_ENABLE_ADDR: begin
                    // Reserved bits are not stored, so they keep their default
                    st_d.refHiEnable = regWrData[REF_HI_W-1:0];
                end
                LOOP_ENABLE_ADDR: begin
                    st_d.loopEnable = regWrData[LOOP_BITS-1:0];
                end
                default: begin
                end
            endcase
        end
        if (regRdEn) begin
            case (regAddr)
                REF_LO_STATUS_ADDR: begin
                    st_d.rdData = refIf.flags[REF_LO_W-1:0];
                end
                REF_HI_STATUS_ADDR: begin
                    st_d.rdData = {5'h00, refIf.flags[NUM_REFS-1:REF_LO_W]};
                end
                LOOP_STATUS_ADDR: begin
                    st_d.rdData = {4'h0, loopIf.flags};
                end
                REF_LO_ENABLE_ADDR: begin
                    st_d.rdData = st_q.refLoEnable;
                end
                REF_HI_ENABLE_ADDR: begin
                    st_d.rdData = {5'h00, st_q.refHiEnable};
                end
                LOOP_ENABLE_ADDR: begin
                    st_d.rdData = {4'h0, st_q.loopEnable};
                end
                HOLD_LOCK_ADDR: begin
                    st_d.rdData = {4'h0, st_q.holdLock};
                end
                default: begin
                    if (isMonAddr(regAddr)) begin
                        st_d.rdData = {3'h0, monIf.flags[idx*NUM_MONS +: NUM_MONS]};
                    end else begin
                        st_d.rdData = UNMAPPED_READ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q.refLoEnable <= ENABLE_RESET;
            st_q.refHiEnable <= ENABLE_RESET[REF_HI_W-1:0];
            st_q.loopEnable <= ENABLE_RESET[LOOP_BITS-1:0];
            st_q.holdLock <= STATUS_RESET[LOOP_BITS-1:0];
            st_q.rdData <= STATUS_RESET;
            st_q.rdValid <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign regRdData = st_q.rdData;
    assign regRdValid = st_q.rdValid;

    loopOneLost_a: assert property (@(posedge clk) disable iff (srst)
        (loopLostLock[1] && st_q.loopEnable[LOOP1_LOST_BIT]) |=> loopIf.flags[LOOP1_LOST_BIT])
        else $error("loop one lost lock not latched");

    loopOneHold_a: assert property (@(posedge clk) disable iff (srst)
        (loopHoldover[1] && st_q.loopEnable[LOOP1_HOLD_BIT]) |=> loopIf.flags[LOOP1_HOLD_BIT])
        else $error("loop one holdover not latched");

    loopZeroLost_a: assert property (@(posedge clk) disable iff (srst)
        (loopLostLock[0] && st_q.loopEnable[LOOP0_LOST_BIT]) |=> loopIf.flags[LOOP0_LOST_BIT])
        else $error("loop zero lost lock not latched");

    loopZeroHold_a: assert property (@(posedge clk) disable iff (srst)
        (loopHoldover[0] && st_q.loopEnable[LOOP0_HOLD_BIT]) |=> loopIf.flags[LOOP0_HOLD_BIT])
        else $error("loop zero holdover not latched");

    loopSticky_a: assert property (@(posedge clk) disable iff (srst)
        (loopIf.flags[LOOP1_LOST_BIT] && !(wrLoop && regWrData[LOOP1_LOST_BIT]))
        |=> loopIf.flags[LOOP1_LOST_BIT])
        else $error("loop status bit dropped without clear");

    loopMasked_a: assert property (@(posedge clk) disable iff (srst)
        (loopIf.flags & ~$past(loopIf.flags) & ~$past(st_q.loopEnable)) == 4'h0)
        else $error("masked loop event reached status");

    irqRaise_a: assert property (@(posedge clk) disable iff (srst)
        (|(loopIf.flags & st_q.loopEnable)) |=> irq)
        else $error("interrupt not raised for loop status");

    irqDrop_a: assert property (@(posedge clk) disable iff (srst)
        (!(|(loopIf.flags & st_q.loopEnable)) && !(|(refIf.flags & refEnable))) |=> !irq)
        else $error("interrupt held with nothing enabled set");

    refSevenMask_a: assert property (@(posedge clk) disable iff (srst)
        $rose(refIf.flags[7]) |-> $past(st_q.refLoEnable[7]))
        else $error("reference seven set while masked");

    refFailSet_a: assert property (@(posedge clk) disable iff (srst)
        (refMonitorFault[0] && refMonitorEnable[0] && st_q.refLoEnable[0]) |=> refIf.flags[0])
        else $error("reference zero failure not latched");

    refHiMask_a: assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == REF_HI_ENABLE_ADDR) |=> (regRdValid && regRdData[7:3] == 5'h00))
        else $error("reserved enable bits read nonzero");

    refStatusRd_a: assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == REF_LO_STATUS_ADDR) |=> (regRdData == $past(refIf.flags[7:0])))
        else $error("reference status read mismatch");

    monUnmasked_a: assert property (@(posedge clk) disable iff (srst)
        refMonitorFault[NUM_MONS] |=> monIf.flags[NUM_MONS])
        else $error("monitor fault not latched");

    holdLockRd_a: assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == HOLD_LOCK_ADDR) |=> (regRdValid && regRdData[7:4] == 4'h0))
        else $error("hold lock read malformed");

    holdLockLive_a: assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == HOLD_LOCK_ADDR) |=> (regRdData[3:0] == $past(loopLive, 2) ||
                                                     $past(srst, 2)))
        else $error("hold lock read not live");

    loopHoldMask_a: assert property (@(posedge clk) disable iff (srst)
        (!st_q.loopEnable[LOOP1_HOLD_BIT] && !loopIf.flags[LOOP1_HOLD_BIT])
        |=> !loopIf.flags[LOOP1_HOLD_BIT])
        else $error("masked loop one holdover latched");

    loopClear_a: assert property (@(posedge clk) disable iff (srst)
        (wrLoop && loopIf.setReq == 4'h0)
        |=> ((loopIf.flags & $past(regWrData[LOOP_BITS-1:0])) == 4'h0))
        else $error("loop status bit not cleared");

    irqRefRaise_a: assert property (@(posedge clk) disable iff (srst)
        (|(refIf.flags & refEnable)) |=> irq)
        else $error("interrupt not raised for reference status");

    refLowMask_a: assert property (@(posedge clk) disable iff (srst)
        (refIf.flags[6:0] & ~$past(refIf.flags[6:0]) & ~$past(st_q.refLoEnable[6:0])) == 7'h00)
        else $error("masked low reference set its status");

    refTenMask_a: assert property (@(posedge clk) disable iff (srst)
        $rose(refIf.flags[10]) |-> $past(st_q.refHiEnable[2]))
        else $error("reference ten set while masked");

    refSticky_a: assert property (@(posedge clk) disable iff (srst)
        (refIf.flags[0] && !(wrRefLo && regWrData[0])) |=> refIf.flags[0])
        else $error("reference status dropped without clear");

    refHiStatusRd_a: assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == REF_HI_STATUS_ADDR)
        |=> (regRdData == {5'h00, $past(refIf.flags[NUM_REFS-1:REF_LO_W])}))
        else $error("high reference status read mismatch");

    monSticky_a: assert property (@(posedge clk) disable iff (srst)
        (monIf.flags[0] && !monClr[0]) |=> monIf.flags[0])
        else $error("monitor fault dropped without clear");

    monRead_a: assert property (@(posedge clk) disable iff (srst)
        (regRdEn && regAddr == MON_FIRST_ADDR) |=> (regRdData == {3'h0, $past(monIf.flags[4:0])}))
        else $error("monitor fault read mismatch");
endmodule
